// ==== hw/quad_card_params.svh ====
`ifndef QUAD_CARD_PARAMS_SVH
`define QUAD_CARD_PARAMS_SVH

// clock and baud reference, in hertz
`define CLK_HZ 20000000
`define REF_HZ 14745600
`define REF_STEP (`REF_HZ / 100)
`define REF_MODULUS (`CLK_HZ / 100)
`define OVERSAMPLE 16

// expansion bus decode
`define PORT_COUNT 4
`define PORT_SPACING 16'h0010
`define BASE_SET_1 16'h0300
`define BASE_SET_2 16'h0400
`define BASE_SET_3 16'h0500
`define BASE_SET_4 16'h0600
`define BASE_SET_5 16'h1500
`define BASE_SET_6 16'h3220
`define BASE_SET_7 16'h4220
`define BASE_NONE 16'h0000
`define IRQ_LINES 8

// register offsets (byte addresses)
`define OFF_DIV0 12'h000
`define OFF_DIV3 12'h00c
`define OFF_CTRL 12'h010
`define OFF_STATUS 12'h014
`define OFF_MASK 12'h018
`define OFF_STATE 12'h01c

// field positions and reset values
`define CTRL_RUN_BIT 0
`define STATE_PEND_BIT 4
`define STATE_SHARED_BIT 5
`define STATE_PULL_BIT 6
`define STATE_SW_LSB 8
`define STATE_JMP_LSB 12
`define DIV_RESET 16'h0060
`define CTRL_RESET 1'b1
`define MASK_RESET 4'h0

`endif

// ==== hw/quad_card_pkg.sv ====
`default_nettype none
package quad_card_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RESP = 3'b100
  } apb_state_type;
endpackage : quad_card_pkg
`default_nettype wire

// ==== hw/port_baud_gen.sv ====
`include "quad_card_params.svh"
`default_nettype none
module port_baud_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ref_en,
  input wire logic [15:0] divisor,
  output logic x16_en,
  output logic bit_en
);
  logic [15:0] cnt;
  logic [3:0] sub;
  logic [15:0] next_cnt;
  logic [3:0] next_sub;
  logic next_x16;
  logic next_bit;

  always_comb begin
    next_cnt = cnt;
    next_sub = sub;
    next_x16 = 1'b0;
    next_bit = 1'b0;
    if (divisor == 16'h0000) begin
      // a zero divisor parks the generator instead of dividing by 65536
      next_cnt = 16'h0000;
      next_sub = 4'h0;
    end else if (ref_en) begin
      // >= so that lowering the divisor mid-count cannot strand the counter
      if (cnt >= divisor - 16'h0001) begin // [R08] [R09]
        next_cnt = 16'h0000;
        next_x16 = 1'b1;
        next_sub = sub + 4'h1;
        if (sub == 4'(`OVERSAMPLE - 1)) begin // [R08]
          next_bit = 1'b1;
        end
      end else begin
        next_cnt = cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0000;
      sub <= 4'h0;
      x16_en <= 1'b0;
      bit_en <= 1'b0;
    end else begin
      cnt <= next_cnt;
      sub <= next_sub;
      x16_en <= next_x16;
      bit_en <= next_bit;
    end
  end

  property p_x16_step;
    @(posedge pclk) disable iff (!presetn)
    (ref_en && divisor != 16'h0000 && cnt >= divisor - 16'h0001) |=> x16_en;
  endproperty
  a_x16_step: assert property (p_x16_step) else $error("x16 tick missing"); // [R09]

  property p_bit_cadence;
    @(posedge pclk) disable iff (!presetn)
    bit_en |-> (x16_en && $past(sub) == 4'hf);
  endproperty
  a_bit_cadence: assert property (p_bit_cadence) else $error("bit tick off cadence"); // [R08]

  property p_div_zero;
    @(posedge pclk) disable iff (!presetn)
    (divisor == 16'h0000) |=> !x16_en;
  endproperty
  a_div_zero: assert property (p_div_zero) else $error("tick with zero divisor"); // [R09]
endmodule : port_baud_gen
`default_nettype wire

// ==== hw/quad_card_glue.sv ====
// Overview of operation
// [R01] each port answers its own 16-address window at the selected base; others ignored
// [R02] switch setting picks port-one base; ports two to four follow at 0x10 steps
// [R03] all base switches off: no address decoded, bus left alone
// [R04] shared mode drives the IRQ line only while a request is pending
// [R05] integrator enables the pull-down on exactly one sharing card
// [R06] the card request goes onto the single line chosen by the jumper
// [R07] baud generators run from a 14.7456 MHz reference
// [R08] divisor one gives 921.6 kbit/s: reference over sixteen over divisor
// [R09] line rate is 921.6 kbit/s divided by the programmed divisor
// [R10] software assuming 1.8432 MHz gets eightfold rates and must scale
//
// The APB slave port and the address map were chosen for this implementation.
`include "quad_card_params.svh"
`default_nettype none
module quad_card_glue (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [15:0] isa_addr,
  input wire logic isa_aen,
  input wire logic isa_ior_n,
  input wire logic isa_iow_n,
  input wire logic [2:0] base_select_switch,
  input wire logic shared_mode_switch,
  input wire logic pulldown_switch,
  input wire logic [2:0] irq_jumper,
  input wire logic [3:0] uart_int,
  output logic [3:0] port_select,
  output logic [7:0] irq_line_out,
  output logic [7:0] irq_line_oe,
  output logic irq_pulldown_en,
  output logic [3:0] baud_x16_en,
  output logic [3:0] baud_bit_en
);

  function automatic logic [15:0] base_of(input logic [2:0] sw);
    logic [15:0] b;
    b = `BASE_NONE;
    case (sw)
      3'h1: b = `BASE_SET_1;
      3'h2: b = `BASE_SET_2;
      3'h3: b = `BASE_SET_3;
      3'h4: b = `BASE_SET_4;
      3'h5: b = `BASE_SET_5;
      3'h6: b = `BASE_SET_6;
      3'h7: b = `BASE_SET_7;
      default: b = `BASE_NONE;
    endcase
    return b;
  endfunction : base_of

  quad_card_pkg::apb_state_type state;
  quad_card_pkg::apb_state_type next_state;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [15:0] div [4];
  logic [15:0] next_div [4];
  logic ctrl_run;
  logic next_ctrl_run;
  logic [3:0] mask;
  logic [3:0] next_mask;
  logic [3:0] status;
  logic [3:0] next_status;
  logic [3:0] status_clear;
  logic [3:0] uart_prev;
  logic [3:0] int_event;
  logic next_irq;
  logic [3:0] next_port_select;
  logic [7:0] next_irq_line_out;
  logic [7:0] next_irq_line_oe;
  logic [17:0] ref_acc;
  logic [17:0] next_ref_acc;
  logic ref_en;
  logic next_ref_en;
  logic [15:0] card_base;

  assign card_base = base_of(base_select_switch);

  // register bus: answer is always two cycles into the access phase
  always_comb begin
    logic [31:0] rd;
    logic hit;
    rd = 32'h0000_0000;
    hit = 1'b1;
    next_state = state;
    next_pready = 1'b0;
    next_prdata = prdata;
    next_pslverr = pslverr;
    next_ctrl_run = ctrl_run;
    next_mask = mask;
    status_clear = 4'h0;
    for (int i = 0; i < `PORT_COUNT; i++) begin
      next_div[i] = div[i];
    end
    if (paddr <= `OFF_DIV3 && paddr[1:0] == 2'b00) begin
      rd = {16'h0000, div[paddr[3:2]]};
    end else if (paddr == `OFF_CTRL) begin
      rd = {31'h0, ctrl_run};
    end else if (paddr == `OFF_STATUS) begin
      rd = {28'h0, status};
    end else if (paddr == `OFF_MASK) begin
      rd = {28'h0, mask};
    end else if (paddr == `OFF_STATE) begin
      rd = 32'h0000_0000;
      rd[3:0] = status & mask;
      rd[`STATE_PEND_BIT] = irq;
      rd[`STATE_SHARED_BIT] = shared_mode_switch;
      rd[`STATE_PULL_BIT] = pulldown_switch;
      rd[`STATE_SW_LSB +: 3] = base_select_switch;
      rd[`STATE_JMP_LSB +: 3] = irq_jumper;
    end else begin
      hit = 1'b0;
    end
    case (state)
      quad_card_pkg::ST_IDLE: begin
        if (psel && !penable) begin
          next_state = quad_card_pkg::ST_WAIT;
        end
      end
      quad_card_pkg::ST_WAIT: begin
        next_pready = 1'b1;
        next_prdata = (hit && !pwrite) ? rd : 32'h0000_0000;
        next_pslverr = !hit;
        next_state = quad_card_pkg::ST_RESP;
      end
      quad_card_pkg::ST_RESP: begin
        next_state = quad_card_pkg::ST_IDLE;
        if (psel && penable && pwrite && !pslverr) begin
          if (paddr <= `OFF_DIV3) begin
            // divisors assume the 14.7456 MHz reference, not 1.8432 MHz
            next_div[paddr[3:2]] = pwdata[15:0]; // [R09] [R10]
          end else if (paddr == `OFF_CTRL) begin
            next_ctrl_run = pwdata[`CTRL_RUN_BIT];
          end else if (paddr == `OFF_STATUS) begin
            status_clear = pwdata[3:0];
          end else if (paddr == `OFF_MASK) begin
            next_mask = pwdata[3:0];
          end
        end
      end
      default: begin
        next_state = quad_card_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= quad_card_pkg::ST_IDLE;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ctrl_run <= `CTRL_RESET;
      mask <= `MASK_RESET;
      for (int i = 0; i < `PORT_COUNT; i++) begin
        div[i] <= `DIV_RESET;
      end
    end else begin
      state <= next_state;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      ctrl_run <= next_ctrl_run;
      mask <= next_mask;
      for (int i = 0; i < `PORT_COUNT; i++) begin
        div[i] <= next_div[i];
      end
    end
  end

  // interrupt capture: a new edge beats a same-cycle clear
  always_comb begin
    int_event = uart_int & ~uart_prev;
    next_status = (status & ~status_clear) | int_event;
    next_irq = |(status & mask);
    for (int i = 0; i < `IRQ_LINES; i++) begin
      if (irq_jumper == 3'(i)) begin
        next_irq_line_oe[i] = shared_mode_switch ? irq : 1'b1; // [R06] [R04]
        next_irq_line_out[i] = shared_mode_switch ? 1'b1 : irq; // [R04]
      end else begin
        next_irq_line_oe[i] = 1'b0;
        next_irq_line_out[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uart_prev <= 4'h0;
      status <= 4'h0;
      irq <= 1'b0;
      irq_line_oe <= 8'h00;
      irq_line_out <= 8'h00;
      irq_pulldown_en <= 1'b0;
    end else begin
      uart_prev <= uart_int;
      status <= next_status;
      irq <= next_irq;
      irq_line_oe <= next_irq_line_oe;
      irq_line_out <= next_irq_line_out;
      // only one sharing card should turn this on
      irq_pulldown_en <= pulldown_switch; // [R05]
    end
  end

  // address decode: one cycle of latency on the chip selects
  always_comb begin
    logic io_cycle;
    logic [15:0] port_base;
    io_cycle = !isa_aen && (!isa_ior_n || !isa_iow_n);
    port_base = card_base;
    for (int i = 0; i < `PORT_COUNT; i++) begin
      port_base = card_base + 16'(i * 16);
      next_port_select[i] = io_cycle && card_base != `BASE_NONE // [R03]
        && isa_addr[15:4] == port_base[15:4]; // [R01] [R02]
    end
  end

  // fractional divider: average enable rate is the reference frequency
  always_comb begin
    logic [18:0] sum;
    sum = {1'b0, ref_acc} + 19'(`REF_STEP);
    next_ref_en = 1'b0;
    next_ref_acc = ref_acc;
    if (ctrl_run) begin
      if (sum >= 19'(`REF_MODULUS)) begin // [R07]
        next_ref_acc = 18'(sum - 19'(`REF_MODULUS));
        next_ref_en = 1'b1;
      end else begin
        next_ref_acc = sum[17:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_select <= 4'h0;
      ref_acc <= 18'h00000;
      ref_en <= 1'b0;
    end else begin
      port_select <= next_port_select;
      ref_acc <= next_ref_acc;
      ref_en <= next_ref_en;
    end
  end

  for (genvar g = 0; g < `PORT_COUNT; g++) begin : g_baud
    port_baud_gen u_baud (
      .pclk(pclk),
      .presetn(presetn),
      .ref_en(ref_en),
      .divisor(div[g]),
      .x16_en(baud_x16_en[g]),
      .bit_en(baud_bit_en[g])
    );
  end

  property p_decode_off;
    @(posedge pclk) disable iff (!presetn)
    (base_select_switch == 3'h0) |=> (port_select == 4'h0);
  endproperty
  a_decode_off: assert property (p_decode_off) else $error("decode with switches off"); // [R03]

  property p_decode_hit;
    @(posedge pclk) disable iff (!presetn)
    (!isa_aen && !isa_ior_n && card_base != `BASE_NONE && isa_addr[15:4] == card_base[15:4])
      |=> port_select == 4'h1;
  endproperty
  a_decode_hit: assert property (p_decode_hit) else $error("port one not selected"); // [R01]

  property p_port_four;
    @(posedge pclk) disable iff (!presetn)
    port_select[3] |-> $past(isa_addr[15:4]) == 12'($past(card_base[15:4]) + 12'h003);
  endproperty
  a_port_four: assert property (p_port_four) else $error("port four spacing wrong"); // [R02]

  property p_idle_bus;
    @(posedge pclk) disable iff (!presetn)
    isa_aen |=> port_select == 4'h0;
  endproperty
  a_idle_bus: assert property (p_idle_bus) else $error("select during dma cycle"); // [R01]

  property p_shared_release;
    @(posedge pclk) disable iff (!presetn)
    (shared_mode_switch && !irq) |=> irq_line_oe == 8'h00;
  endproperty
  a_shared_release: assert property (p_shared_release) else $error("shared line held"); // [R04]

  property p_one_line;
    @(posedge pclk) disable iff (!presetn)
    ##1 $onehot0(irq_line_oe) && (irq_line_oe & ~(8'h01 << $past(irq_jumper))) == 8'h00;
  endproperty
  a_one_line: assert property (p_one_line) else $error("irq on wrong line"); // [R06]

  property p_ref_density;
    @(posedge pclk) disable iff (!presetn)
    ctrl_run ##1 (ctrl_run && !ref_en) |=> ref_en;
  endproperty
  a_ref_density: assert property (p_ref_density) else $error("reference enable too sparse"); // [R07]

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
    (uart_int[0] && !uart_prev[0]) |=> status[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("interrupt event lost");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
    ##1 irq == |($past(status) & $past(mask));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq output wrong");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
endmodule : quad_card_glue
`default_nettype wire

// ==== test/isa_host_model.sv ====
`default_nettype none
module isa_host_model (
  input wire logic pclk,
  input wire logic [7:0] irq_line_out,
  input wire logic [7:0] irq_line_oe,
  output logic [15:0] isa_addr,
  output logic isa_aen,
  output logic isa_ior_n,
  output logic isa_iow_n,
  output logic [7:0] irq_wire
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    isa_addr = 16'hffff;
    isa_aen = 1'b0;
    isa_ior_n = 1'b1;
    isa_iow_n = 1'b1;
  end
  // a released line falls to the one pull-down among the sharing cards
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      irq_wire[i] = irq_line_oe[i] ? irq_line_out[i] : 1'b0;
    end
  end
  task automatic io_cycle(input logic [15:0] a, input logic wr, input logic dma);
    @(posedge pclk);
    isa_addr <= a;
    isa_aen <= dma;
    isa_ior_n <= wr;
    isa_iow_n <= !wr;
    @(posedge pclk);
    isa_ior_n <= 1'b1;
    isa_iow_n <= 1'b1;
    isa_aen <= 1'b0;
    // idle address shows no stale value
    isa_addr <= ~a;
  endtask : io_cycle
endmodule : isa_host_model
`default_nettype wire

// ==== test/quad_uart_card_decode_baud_tb_top.sv ====
`include "quad_card_params.svh"
`default_nettype none
module quad_uart_card_decode_baud_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int W = 40000;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq, isa_aen, isa_ior_n, isa_iow_n, irq_pulldown_en;
  logic [15:0] isa_addr;
  logic [2:0] base_select_switch = 3'h0, irq_jumper = 3'h0;
  logic shared_mode_switch = 1'b0, pulldown_switch = 1'b0;
  logic [3:0] uart_int = 4'h0, port_select, baud_x16_en, baud_bit_en;
  logic [7:0] irq_line_out, irq_line_oe, irq_wire, one;
  logic [32:0] apb_q[$];
  logic [3:0] dec_q[$];
  logic dec_pend = 1'b0, counting = 1'b0;
  logic [15:0] bases [8] = '{16'h0000, 16'h0300, 16'h0400, 16'h0500, 16'h0600,
                             16'h1500, 16'h3220, 16'h4220};
  int divs [4] = '{1, 2, 8, 96};
  int bit_cnt [4] = '{0, 0, 0, 0};
  int x16_cnt [4] = '{0, 0, 0, 0};
  int n_mismatch = 0, total_checks = 0, jmp, refs;
  always #25 pclk = ~pclk;
  quad_card_glue dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .isa_addr(isa_addr), .isa_aen(isa_aen),
    .isa_ior_n(isa_ior_n), .isa_iow_n(isa_iow_n), .base_select_switch(base_select_switch),
    .shared_mode_switch(shared_mode_switch), .pulldown_switch(pulldown_switch),
    .irq_jumper(irq_jumper), .uart_int(uart_int), .port_select(port_select),
    .irq_line_out(irq_line_out), .irq_line_oe(irq_line_oe),
    .irq_pulldown_en(irq_pulldown_en), .baud_x16_en(baud_x16_en), .baud_bit_en(baud_bit_en));
  isa_host_model host_u (.pclk(pclk), .irq_line_out(irq_line_out), .irq_line_oe(irq_line_oe),
    .isa_addr(isa_addr), .isa_aen(isa_aen), .isa_ior_n(isa_ior_n), .isa_iow_n(isa_iow_n),
    .irq_wire(irq_wire));
  task automatic chk_word(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_count(input int got, input int exp);
    total_checks++;
    if (got > exp + 2 || got < exp - 2) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_count
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  function automatic logic [3:0] exp_sel(input logic [2:0] sw, input logic [15:0] a,
                                         input logic dma);
    logic [15:0] d;
    exp_sel = 4'h0;
    d = a - bases[sw];
    if (sw != 3'h0 && !dma && d < 16'h0040) exp_sel = 4'h1 << d[5:4];
  endfunction : exp_sel
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    apb_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic io(input logic [15:0] a, input logic wr, input logic dma);
    dec_q.push_back(exp_sel(base_select_switch, a, dma));
    host_u.io_cycle(a, wr, dma);
  endtask : io
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      chk_word({pslverr, prdata}, apb_q.pop_front());
    end
    if (dec_pend) begin
      chk_word({29'h0, port_select}, {29'h0, dec_q.pop_front()});
    end
    dec_pend <= (isa_ior_n === 1'b0) || (isa_iow_n === 1'b0);
    if (counting) begin
      for (int p = 0; p < 4; p++) begin
        bit_cnt[p] <= bit_cnt[p] + int'(baud_bit_en[p] === 1'b1);
        x16_cnt[p] <= x16_cnt[p] + int'(baud_x16_en[p] === 1'b1);
      end
    end
  end
  initial begin
    #3000000;
    n_mismatch++;
    $display("watchdog expired");
    tally_and_finish();
  end
  initial begin
    void'($urandom(41));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int p = 0; p < 4; p++) apb(1'b0, 12'(4 * p), 32'h0, {1'b0, 32'h60});
    apb(1'b0, `OFF_STATUS, 32'h0, 33'h0);
    apb(1'b0, `OFF_MASK, 32'h0, 33'h0);
    apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h024, $urandom, {1'b1, 32'h0});
    $display("test registers done");
    for (int sw = 0; sw < 8; sw++) begin
      base_select_switch <= 3'(sw);
      repeat (2) @(posedge pclk);
      for (int n = 0; n < 4; n++) begin
        io(bases[sw] + 16'(16 * n) + 16'($urandom_range(15)), 1'(n), 1'b0);
      end
      io(bases[sw] + 16'h0040, 1'b0, 1'b0);
      io(bases[sw] - 16'h0010, 1'b1, 1'b0);
      io(bases[sw], 1'b0, 1'b1);
    end
    repeat (3) @(posedge pclk);
    $display("test decode done");
    for (int sh = 0; sh < 2; sh++) begin
      jmp = $urandom_range(7);
      one = 8'h1 << jmp;
      shared_mode_switch <= 1'(sh);
      pulldown_switch <= 1'(sh);
      irq_jumper <= 3'(jmp);
      apb(1'b1, `OFF_MASK, 32'h1, 33'h0);
      @(posedge pclk);
      uart_int <= 4'h1;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      chk_word({irq, irq_line_oe, irq_line_out, irq_wire, 1'(irq_pulldown_en)},
               {1'b1, one, one, one, 1'(sh)});
      @(posedge pclk);
      uart_int <= 4'h3;
      @(posedge pclk);
      uart_int <= 4'h0;
      apb(1'b1, `OFF_STATUS, 32'h1, 33'h0);
      apb(1'b0, `OFF_STATUS, 32'h0, 33'h2);
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk_word({irq, irq_line_oe, irq_line_out, irq_wire},
               {1'b0, sh ? 8'h0 : one, sh ? one : 8'h0, 8'h0});
      apb(1'b0, `OFF_STATE, 32'h0,
          {18'h0, 3'(jmp), 1'b0, 3'h7, 1'b0, 1'(sh), 1'(sh), 5'h0});
      apb(1'b1, `OFF_STATUS, 32'h2, 33'h0);
    end
    $display("test interrupt done");
    // divisors written for the fast reference, not the conventional one
    for (int p = 0; p < 4; p++) apb(1'b1, 12'(4 * p), 32'(divs[p]), 33'h0);
    repeat (50) @(posedge pclk);
    counting <= 1'b1;
    repeat (W) @(posedge pclk);
    counting <= 1'b0;
    @(posedge pclk);
    refs = W * 2304 / 3125;
    for (int p = 0; p < 4; p++) chk_count(x16_cnt[p], refs / divs[p]);
    for (int p = 0; p < 4; p++) chk_count(bit_cnt[p], refs / (16 * divs[p]));
    $display("test baud done");
    // zero divisor parks port one, clearing run stops every generator
    apb(1'b1, `OFF_DIV0, 32'h0, 33'h0);
    apb(1'b1, `OFF_CTRL, 32'h0, 33'h0);
    apb(1'b0, `OFF_CTRL, 32'h0, 33'h0);
    repeat (4) @(posedge pclk);
    for (int p = 0; p < 4; p++) x16_cnt[p] <= 0;
    counting <= 1'b1;
    repeat (200) @(posedge pclk);
    counting <= 1'b0;
    @(posedge pclk);
    for (int p = 0; p < 4; p++) chk_word(33'(x16_cnt[p]), 33'h0);
    $display("test stop done");
    tally_and_finish();
  end
endmodule : quad_uart_card_decode_baud_tb_top
`default_nettype wire
